// ### dpcc_cfg.svh
// constants of the dual loop channel control block
`ifndef DPCC_CFG_SVH
`define DPCC_CFG_SVH
`define DPCC_REF_DIV        12'h800
`define DPCC_REF_DIV_W      12
`define DPCC_TONE_KHZ       5
`define DPCC_N_W            14
`define DPCC_DEFAULT_CH     4'h1
`define DPCC_LOCK_WIN       4'h2
`define DPCC_APB_CTRL       12'h000
`define DPCC_APB_STATUS     12'h004
`define DPCC_APB_IRQ_STAT   12'h008
`define DPCC_APB_IRQ_MASK   12'h00C
`define DPCC_CTRL_SERIAL    0
`define DPCC_CTRL_BASE      1
`define DPCC_IRQ_UNLOCK     0
`define DPCC_IRQ_LOAD       1
`endif

// ### dpcc_pkg.sv
// types of the dual loop channel control block
package dpcc_pkg;
  typedef struct packed {
    logic [13:0] rx_n;
    logic [13:0] tx_n;
  } dpcc_ratio_type;
  typedef struct packed {
    logic up;
    logic dn;
  } dpcc_pd_type;
  typedef struct packed {
    logic [11:0] ref_cnt;
    logic        ref_pulse;
    logic        tone;
    logic [13:0] rx_cnt;
    logic [13:0] tx_cnt;
    logic        rx_fv;
    logic        tx_fv;
    logic        rx_prev;
    logic        tx_prev;
    dpcc_pd_type rx_pd;
    dpcc_pd_type tx_pd;
    logic [3:0]  shift;
    logic [3:0]  latch;
    logic        sclk_prev;
    logic        load_prev;
    logic [3:0]  err_cnt;
    logic        unlock;
    logic        ctrl_serial;
    logic        ctrl_base;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [31:0] prdata;
  } dpcc_state_type;
endpackage : dpcc_pkg

// ### dpcc_top.sv
// dual loop channel control: reference divider, counters, phase detectors, channel select
// Function
// - one shared reference divider feeds both loops
// - separate ROM-selected divide-by-N counters, each with own phase detector
// - lock detection exists only on transmit loop
// - continuous 5 kHz tone divided from reference
// - station select high means base, low handset; part of ROM address
// - station select pulled down, open pin gives handset
// - power save low disables transmit loop; pulled down when open
// - 4-bit parallel code picks one of 15 channel pairs
// - codes outside 1 to 15 become channel 1
// - parallel code pins pulled down, open pins give channel 1
// - reference from crystal or external signal; output unused then
// - serial variant loads code by shift register into same ROM
// - serial data MSB first, one bit per serial clock rising edge
// - load strobe pulse transfers shift register into channel latch
// - lock flag high while transmit loop out of lock
// - serial latch starts at channel 1; illegal latched codes give channel 1
`include "dpcc_cfg.svh"
module dpcc_top
  import dpcc_pkg::*;
#(
  parameter int REF_DIV = `DPCC_REF_DIV
)(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_ref_osc_input,
  input  wire logic        i_rx_vco_input,
  input  wire logic        i_tx_vco_input,
  input  wire logic        i_station_select,
  input  wire logic        i_power_save_select,
  input  wire logic [3:0]  i_channel_code_bits,
  input  wire logic        i_serial_data,
  input  wire logic        i_serial_clk,
  input  wire logic        i_latch_load_strobe,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq,
  output logic             o_ref_osc_output,
  output logic             o_tone,
  output logic             o_lock_flag_out,
  output logic             o_tx_phase_err_out,
  output logic             o_tx_phase_err_oe,
  output logic             o_rx_phase_err_out,
  output logic             o_rx_phase_err_oe
);

  dpcc_state_type state;
  dpcc_state_type next_state;
  dpcc_ratio_type ratio;
  logic [3:0]     code;
  logic [3:0]     chan;
  logic           tx_on;
  logic           sclk_rise;
  logic           load_rise;
  logic           apb_wr;
  logic           apb_rd;
  logic           addr_ok;

  // channel ROM: rx and tx divide ratios by channel and base/handset
  function automatic dpcc_ratio_type dpcc_rom(input logic [3:0] ch, input logic base);
    dpcc_ratio_type r;
    logic [3:0]     c;
    r = '0;
    c = (ch == 4'h0) ? `DPCC_DEFAULT_CH : ch;
    case ({base, c})
      5'h01: r = '{14'd7183, 14'd9934};
      5'h02: r = '{14'd7187, 14'd9969};
      5'h03: r = '{14'd7195, 14'd9972};
      5'h04: r = '{14'd7203, 14'd9954};
      5'h05: r = '{14'd7207, 14'd9975};
      5'h06: r = '{14'd7215, 14'd9966};
      5'h07: r = '{14'd7227, 14'd9978};
      5'h08: r = '{14'd7235, 14'd9986};
      5'h09: r = '{14'd7247, 14'd9998};
      5'h0A: r = '{14'd7255, 14'd9994};
      5'h0B: r = '{14'd7163, 14'd9939};
      5'h0C: r = '{14'd7167, 14'd9942};
      5'h0D: r = '{14'd7171, 14'd9945};
      5'h0E: r = '{14'd7175, 14'd9948};
      5'h0F: r = '{14'd7179, 14'd9951};
      5'h11: r = '{14'd7795, 14'd9322};
      5'h12: r = '{14'd7830, 14'd9326};
      5'h13: r = '{14'd7833, 14'd9334};
      5'h14: r = '{14'd7815, 14'd9342};
      5'h15: r = '{14'd7836, 14'd9346};
      5'h16: r = '{14'd7827, 14'd9354};
      5'h17: r = '{14'd7839, 14'd9366};
      5'h18: r = '{14'd7847, 14'd9374};
      5'h19: r = '{14'd7859, 14'd9386};
      5'h1A: r = '{14'd7855, 14'd9394};
      5'h1B: r = '{14'd7800, 14'd9302};
      5'h1C: r = '{14'd7803, 14'd9306};
      5'h1D: r = '{14'd7806, 14'd9310};
      5'h1E: r = '{14'd7809, 14'd9314};
      5'h1F: r = '{14'd7812, 14'd9318};
      default: r = '{14'd7183, 14'd9934};
    endcase
    return r;
  endfunction : dpcc_rom

  // phase/frequency detector; up or down is held from its edge until the other edge arrives
  function automatic dpcc_pd_type dpcc_pfd(input dpcc_pd_type pd, input logic fr,
                                            input logic fv);
    dpcc_pd_type p;
    p = pd;
    if (fr)
    begin
      p.up = 1'b1;
    end
    if (fv)
    begin
      p.dn = 1'b1;
    end
    if (p.up && p.dn)
    begin
      p = '0; // both edges seen: coincidence, go idle
    end
    return p;
  endfunction : dpcc_pfd

  // pins are taken as driven; pull-downs are the pad's job, open reads as zero
  assign tx_on     = i_power_save_select;
  assign sclk_rise = i_serial_clk & ~state.sclk_prev;
  assign load_rise = i_latch_load_strobe & ~state.load_prev;
  assign code      = state.ctrl_serial ? state.latch : i_channel_code_bits;
  assign ratio     = dpcc_rom(code, i_station_select | state.ctrl_base);
  // status shows the channel really in use, so code 0 reads back as channel 1
  assign chan      = (code == 4'h0) ? `DPCC_DEFAULT_CH : code;
  assign apb_wr    = i_psel & i_penable & i_pwrite;
  assign apb_rd    = i_psel & ~i_penable & ~i_pwrite;
  assign addr_ok   = (i_paddr == `DPCC_APB_CTRL) || (i_paddr == `DPCC_APB_STATUS) ||
                     (i_paddr == `DPCC_APB_IRQ_STAT) || (i_paddr == `DPCC_APB_IRQ_MASK);

  // next state of the whole block
  always_comb
  begin
    next_state = state;
    next_state.sclk_prev = i_serial_clk;
    next_state.load_prev = i_latch_load_strobe;
    // shared reference divider, counts every i_mclk cycle; oscillator level is not sampled
    next_state.rx_prev = i_rx_vco_input;
    next_state.tx_prev = i_tx_vco_input;
    next_state.ref_pulse = 1'b0;
    if (state.ref_cnt == 12'(REF_DIV - 1))
    begin
      next_state.ref_cnt   = '0;
      next_state.ref_pulse = 1'b1;
    end
    else
    begin
      next_state.ref_cnt = state.ref_cnt + 12'h001;
    end
    // tone is high for the upper half of the reference count
    // compare against half the divide so any even REF_DIV gives a square wave
    next_state.tone = (state.ref_cnt >= 12'(REF_DIV / 2));
    // divide-by-N counters count vco rising edges
    next_state.rx_fv = 1'b0;
    next_state.tx_fv = 1'b0;
    if (i_rx_vco_input && !state.rx_prev)
    begin
      if (state.rx_cnt >= ratio.rx_n - 14'h0001)
      begin
        next_state.rx_cnt = '0;
        next_state.rx_fv  = 1'b1;
      end
      else
      begin
        next_state.rx_cnt = state.rx_cnt + 14'h0001;
      end
    end
    if (!tx_on)
    begin
      next_state.tx_cnt = '0;
    end
    else if (i_tx_vco_input && !state.tx_prev)
    begin
      if (state.tx_cnt >= ratio.tx_n - 14'h0001)
      begin
        next_state.tx_cnt = '0;
        next_state.tx_fv  = 1'b1;
      end
      else
      begin
        next_state.tx_cnt = state.tx_cnt + 14'h0001;
      end
    end
    next_state.rx_pd = dpcc_pfd(state.rx_pd, state.ref_pulse, state.rx_fv);
    next_state.tx_pd = tx_on ? dpcc_pfd(state.tx_pd, state.ref_pulse, state.tx_fv) : '0;
    // lock: count reference periods with unresolved phase error; transmit only
    if (!tx_on)
    begin
      next_state.err_cnt = '0;
      next_state.unlock  = 1'b0;
    end
    else if (state.ref_pulse)
    begin
      if (state.tx_pd.up || state.tx_pd.dn)
      begin
        next_state.err_cnt = (state.err_cnt == 4'hF) ? 4'hF : state.err_cnt + 4'h1;
      end
      else
      begin
        next_state.err_cnt = '0;
      end
      next_state.unlock = (next_state.err_cnt >= `DPCC_LOCK_WIN);
    end
    // serial shift register and load strobe
    if (sclk_rise)
    begin
      next_state.shift = {state.shift[2:0], i_serial_data};
    end
    if (load_rise)
    begin
      next_state.latch = state.shift;
    end
    // register writes, in access phase only
    if (apb_wr && i_paddr == `DPCC_APB_CTRL)
    begin
      next_state.ctrl_serial = i_pwdata[`DPCC_CTRL_SERIAL];
      next_state.ctrl_base   = i_pwdata[`DPCC_CTRL_BASE];
    end
    if (apb_wr && i_paddr == `DPCC_APB_IRQ_MASK)
    begin
      next_state.irq_mask = i_pwdata[1:0];
    end
    if (apb_wr && i_paddr == `DPCC_APB_IRQ_STAT)
    begin
      next_state.irq_stat = state.irq_stat & ~i_pwdata[1:0];
    end
    // set beats clear in the same cycle
    if (next_state.unlock && !state.unlock)
    begin
      next_state.irq_stat[`DPCC_IRQ_UNLOCK] = 1'b1;
    end
    if (load_rise)
    begin
      next_state.irq_stat[`DPCC_IRQ_LOAD] = 1'b1;
    end
    // read data captured in setup so it is stable in the access phase
    if (apb_rd)
    begin
      case (i_paddr)
        `DPCC_APB_CTRL:     next_state.prdata = {30'h0, state.ctrl_base, state.ctrl_serial};
        `DPCC_APB_STATUS:   next_state.prdata = {20'h0, chan, state.latch, 2'h0, tx_on,
                                                 state.unlock};
        `DPCC_APB_IRQ_STAT: next_state.prdata = {30'h0, state.irq_stat};
        `DPCC_APB_IRQ_MASK: next_state.prdata = {30'h0, state.irq_mask};
        default:            next_state.prdata = 32'h0000_0000;
      endcase
    end
  end

  // single state register; latch resets to channel 1
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state       <= '0;
      state.latch <= `DPCC_DEFAULT_CH;
    end
    else
    begin
      state <= next_state;
    end
  end

  // outputs; phase outputs idle (not driven) when neither pulse is active
  assign o_prdata           = state.prdata;
  assign o_pready           = 1'b1;
  assign o_pslverr          = i_psel & i_penable & ~addr_ok;
  assign o_irq              = |(state.irq_stat & state.irq_mask);
  assign o_ref_osc_output   = i_ref_osc_input;
  assign o_tone             = state.tone;
  assign o_lock_flag_out    = state.unlock;
  assign o_tx_phase_err_out = state.tx_pd.up;
  assign o_tx_phase_err_oe  = state.tx_pd.up ^ state.tx_pd.dn;
  assign o_rx_phase_err_out = state.rx_pd.up;
  assign o_rx_phase_err_oe  = state.rx_pd.up ^ state.rx_pd.dn;

endmodule : dpcc_top

// ### dpcc_top_sva.sv
// assertion checker for the dual loop channel control top
module dpcc_top_sva #(
  parameter int REF_DIV = 16
)(
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic        i_ref_osc_input,
  input wire logic        i_power_save_select,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_ref_osc_output,
  input wire logic        o_tone,
  input wire logic        o_lock_flag_out,
  input wire logic        o_tx_phase_err_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  logic acc;
  logic mapped;
  // access phase and decode of the four register words
  assign acc = i_psel && i_penable;
  assign mapped = i_paddr inside {12'h000, 12'h004, 12'h008, 12'h00C};
  a_ref_buffer: assert property (o_ref_osc_output == i_ref_osc_input)
    else $error("reference buffer differs");
  a_ready_high: assert property (o_pready)
    else $error("ready low");
  // half period of 8 holds only for the REF_DIV of 16 the bench uses
  a_tone_half: assert property ($changed(o_tone) |=> $stable(o_tone)[*7] ##1 $changed(o_tone))
    else $error("tone period wrong");
  a_bad_addr: assert property (acc && !mapped |-> o_pslverr)
    else $error("unmapped access not refused");
  a_good_addr: assert property (acc && mapped |-> !o_pslverr)
    else $error("mapped access refused");
  a_bad_read: assert property (acc && !i_pwrite && !mapped |-> o_prdata == 32'h0)
    else $error("unmapped read not zero");
  a_tx_idle: assert property (!i_power_save_select[*3] |-> !o_tx_phase_err_oe)
    else $error("tx detector active in standby");
  a_lock_idle: assert property (!i_power_save_select[*3] |-> !o_lock_flag_out)
    else $error("lock flag set in standby");
  c_refused: cover property (acc && !mapped);
  c_unlock: cover property ($rose(o_lock_flag_out));
  c_standby: cover property ($fell(i_power_save_select));
endmodule : dpcc_top_sva

bind dpcc_top dpcc_top_sva #(.REF_DIV(REF_DIV)) dpcc_top_sva_inst (.i_mclk, .i_reset_n,
  .i_ref_osc_input, .i_power_save_select, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .o_prdata, .o_pready, .o_pslverr, .o_ref_osc_output, .o_tone, .o_lock_flag_out,
  .o_tx_phase_err_oe);

// ### dpcc_vco_model.sv
// behavioural loop oscillator standing in for one vco
module dpcc_vco_model (
  input  wire logic       i_mclk,
  input  wire logic [3:0] i_half,
  output logic            o_vco = 1'b0
);
  logic [3:0] cnt = 4'h0;
  // free running square wave; a real vco never stops between frames
  always @(posedge i_mclk)
  begin
    cnt <= (cnt >= i_half) ? 4'h0 : cnt + 4'h1;
    if (cnt >= i_half)
      o_vco <= ~o_vco;
  end
endmodule : dpcc_vco_model

// ### tb_top.sv
// self-checking bench for the dual loop channel control top
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 0, i_reset_n = 0, i_ref_osc_input = 0, i_station_select = 0;
  logic i_power_save_select = 0, i_serial_data = 0, i_serial_clk = 0;
  logic i_latch_load_strobe = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [3:0] i_channel_code_bits = 0, rxh = 4'h3, txh = 4'h6;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, rd;
  logic i_rx_vco_input, i_tx_vco_input, o_pready, o_pslverr, o_irq, o_lock_flag_out, se;
  int err_count = 0, checked = 0, cyc = 0, seed = 32'hFB4AF626;
  dpcc_vco_model rx_vco_inst (.i_mclk, .i_half(rxh), .o_vco(i_rx_vco_input));
  dpcc_vco_model tx_vco_inst (.i_mclk, .i_half(txh), .o_vco(i_tx_vco_input));
  // short reference divide keeps tone and lock checks quick
  dpcc_top #(.REF_DIV(16)) dpcc_top_inst (.i_mclk, .i_reset_n, .i_ref_osc_input,
    .i_rx_vco_input, .i_tx_vco_input, .i_station_select, .i_power_save_select,
    .i_channel_code_bits, .i_serial_data, .i_serial_clk, .i_latch_load_strobe, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_irq,
    .o_ref_osc_output(), .o_tone(), .o_lock_flag_out, .o_tx_phase_err_out(),
    .o_tx_phase_err_oe(), .o_rx_phase_err_out(), .o_rx_phase_err_oe());
  initial forever #25 i_mclk = ~i_mclk;
  // reference toggles each cycle; a hang is cut off far beyond the normal run
  always @(posedge i_mclk)
  begin
    i_ref_osc_input <= ~i_ref_osc_input;
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  task end_sim;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      err_count++;
  endtask : chk
  // one apb transfer; request held until ready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    rd = o_prdata;
    se = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_mclk);
  endtask : apb
  // controller side of the serial load; data inverted once its hold is over
  task ser(input logic [3:0] v);
    for (int i = 3; i >= 0; i--)
    begin
      i_serial_data <= v[i];
      repeat (2) @(posedge i_mclk);
      i_serial_clk <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_serial_clk <= 1'b0;
      @(posedge i_mclk);
      i_serial_data <= ~v[i];
      @(posedge i_mclk);
    end
    i_latch_load_strobe <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_latch_load_strobe <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask : ser
  function logic [3:0] eff(input logic [3:0] c);
    return (c == 4'h0) ? 4'h1 : c;
  endfunction : eff
  initial
  begin
    logic [3:0] c;
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(posedge i_mclk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'hF0, 32'h10);
    // every parallel code once, then random ones
    for (int k = 0; k < 24; k++)
    begin
      c = (k < 16) ? k[3:0] : 4'($random(seed));
      i_channel_code_bits <= c;
      i_station_select <= 1'($random(seed));
      repeat (3) @(posedge i_mclk);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd & 32'hF00, {20'h0, eff(c), 8'h0});
    end
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h00C, 32'h2);
    for (int k = 0; k < 4; k++)
    begin
      c = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($random(seed));
      ser(c);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd & 32'hFF0, {20'h0, eff(c), c, 4'h0});
      @(posedge i_mclk);
      chk({31'h0, o_irq}, 32'h1);
      apb(1'b1, 12'h008, 32'h2);
      @(posedge i_mclk);
      chk({31'h0, o_irq}, 32'h0);
    end
    apb(1'b0, 12'h010, 32'h0);
    chk({se, rd[30:0]}, 32'h80000000);
    rxh <= 4'($random(seed));
    txh <= 4'($random(seed));
    i_power_save_select <= 1'b1;
    repeat (200) @(posedge i_mclk);
    chk({31'h0, o_lock_flag_out}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h3, 32'h3);
    i_power_save_select <= 1'b0;
    repeat (5) @(posedge i_mclk);
    chk({31'h0, o_lock_flag_out}, 32'h0);
    end_sim();
  end
endmodule : tb_top
